// ---- design/mfc_push_ctrl.sv ----
// Meter push-function controller: ranging, hold, relative, max/min, inrush, zero
`timescale 1ns/1ps
`default_nettype none
`include "mfc_regs.svh"

module mfc_push_ctrl #(
    parameter int unsigned LONG_PRESS_CYCLES = `MFC_LONG_PRESS_MS * `MFC_CLK_KHZ
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RESET,
    input wire logic I_RANGE_BTN_N,
    input wire logic I_HOLD_BTN_N,
    input wire logic I_REL_BTN_N,
    input wire logic I_MAXMIN_BTN_N,
    input wire logic I_KEY_BTN_N,
    input wire logic I_ZERO_BTN_N,
    input wire logic I_CLAMP_CAP_LIMIT_PIN_N,
    input wire logic I_INRUSH_ENABLE_PIN_N,
    input wire logic I_FUNCTION_CODE_BIT_FIVE,
    input wire mfc_pkg::mfc_mode_t I_MEAS_MODE,
    input wire logic I_CONV_VALID,
    input wire logic signed [15:0] I_CONV_VALUE,
    input wire logic I_AUTO_UP,
    input wire logic I_AUTO_DOWN,
    input wire logic I_INRUSH_DET,
    output logic [2:0] O_RANGE,
    output logic O_AUTO,
    output logic signed [15:0] O_DISP_VALUE,
    output logic O_DISP_DASHES,
    output logic O_OVERLOAD_INDICATION,
    output logic O_RELATIVE_MODE,
    output logic O_HOLD,
    output mfc_pkg::mfc_mm_t O_MAXMIN_SEL,
    output logic O_INRUSH,
    output logic O_ZERO
);

    mfc_pkg::mfc_state_t r;
    mfc_pkg::mfc_state_t n;
    logic [`MFC_BTN_NUM-1:0] btn_n;
    logic [`MFC_BTN_NUM-1:0] b_press;
    logic [`MFC_BTN_NUM-1:0] b_short;
    logic [`MFC_BTN_NUM-1:0] b_long;
    logic lim_low;
    logic ir_enabled;
    logic fc5;
    logic [2:0] lo_auto;
    logic [2:0] lo_man;
    logic [2:0] hi;
    logic signed [15:0] v;
    logic v_over;
    logic signed [15:0] shown;

    // Magnitude of a signed count
    function automatic logic signed [15:0] mag(input logic signed [15:0] x);
        mag = (x < 16'sh0000) ? -x : x;
    endfunction : mag

    // Modes without any range choice
    function automatic logic is_fixed(input mfc_pkg::mfc_mode_t m);
        is_fixed = (m == mfc_pkg::MODE_FIXED) || (m == mfc_pkg::MODE_ACA_MAN) ||
                   (m == mfc_pkg::MODE_DCA_MAN);
    endfunction : is_fixed

    // Lowest range, automatic or manual
    function automatic logic [2:0] range_lo(input mfc_pkg::mfc_mode_t m, input logic auto_on);
        case (m)
            mfc_pkg::MODE_VOLT: range_lo = auto_on ? `MFC_VOLT_AUTO_LO : `MFC_RANGE_ONE;
            mfc_pkg::MODE_CLAMP_CAP: range_lo = `MFC_CCAP_LO;
            default: range_lo = `MFC_RANGE_ONE;
        endcase
    endfunction : range_lo

    // Highest range of the mode
    function automatic logic [2:0] range_hi(input mfc_pkg::mfc_mode_t m, input logic lim);
        case (m)
            mfc_pkg::MODE_VOLT: range_hi = `MFC_VOLT_HI;
            mfc_pkg::MODE_TWO_RANGE: range_hi = `MFC_TWO_HI;
            mfc_pkg::MODE_ACA_AUTO: range_hi = `MFC_TWO_HI;
            mfc_pkg::MODE_DCA_AUTO: range_hi = `MFC_TWO_HI;
            mfc_pkg::MODE_CAP: range_hi = `MFC_CAP_HI;
            mfc_pkg::MODE_CLAMP_CAP: range_hi = lim ? `MFC_CCAP_HI_LIM : `MFC_CAP_HI;
            mfc_pkg::MODE_RES: range_hi = `MFC_SIX_HI;
            mfc_pkg::MODE_FREQ: range_hi = `MFC_SIX_HI;
            default: range_hi = `MFC_RANGE_ONE;
        endcase
    endfunction : range_hi

    // Range taken on entry to a mode
    function automatic logic [2:0] range_init(input mfc_pkg::mfc_mode_t m);
        case (m)
            mfc_pkg::MODE_VOLT: range_init = `MFC_VOLT_INIT;
            mfc_pkg::MODE_CLAMP_CAP: range_init = `MFC_CCAP_LO;
            default: range_init = `MFC_RANGE_ONE;
        endcase
    endfunction : range_init

    assign btn_n[`MFC_BTN_RANGE] = I_RANGE_BTN_N;
    assign btn_n[`MFC_BTN_HOLD] = I_HOLD_BTN_N;
    assign btn_n[`MFC_BTN_REL] = I_REL_BTN_N;
    assign btn_n[`MFC_BTN_MAXMIN] = I_MAXMIN_BTN_N;
    assign btn_n[`MFC_BTN_KEY] = I_KEY_BTN_N;
    assign btn_n[`MFC_BTN_ZERO] = I_ZERO_BTN_N;

    // One conditioner per push button
    genvar gi;
    generate
        for (gi = 0; gi < `MFC_BTN_NUM; gi = gi + 1) begin : g_btn
            mfc_button #(
                .LONG_CYCLES(LONG_PRESS_CYCLES)
            ) u_btn (
                .i_clk(I_CORE_CLK),
                .i_reset(I_RESET),
                .i_btn_n(btn_n[gi]),
                .o_press(b_press[gi]),
                .o_short(b_short[gi]),
                .o_long(b_long[gi])
            );
        end
    endgenerate

    // Synchronised strap levels and range bounds
    always_comb begin
        lim_low = ~r.strap_s2[2];
        ir_enabled = ~r.strap_s2[1];
        fc5 = r.strap_s2[0];
        lo_auto = range_lo(I_MEAS_MODE, 1'b1);
        lo_man = range_lo(I_MEAS_MODE, 1'b0);
        hi = range_hi(I_MEAS_MODE, lim_low);
    end

    // Offset-corrected value and its overload flag
    always_comb begin
        v = I_CONV_VALUE - r.offset;
        v_over = mag(I_CONV_VALUE) > `MFC_FULL_SCALE;
        if (r.relative_mode) begin
            v_over = v_over || r.ref_over || (mag(v) > `MFC_REL_LIMIT);
        end
    end

    // Controller next state
    always_comb begin
        n = r;
        shown = r.disp_val;
        n.strap_s1 = {I_CLAMP_CAP_LIMIT_PIN_N, I_INRUSH_ENABLE_PIN_N, I_FUNCTION_CODE_BIT_FIVE};
        n.strap_s2 = r.strap_s1;
        n.mode = I_MEAS_MODE;

        // Conversion: track extremes, refresh display
        if (I_CONV_VALID) begin
            n.last_conv = I_CONV_VALUE;
            if (!r.hold && r.maxmin != mfc_pkg::MM_OFF) begin
                if (v > r.max_val) begin
                    n.max_val = v;
                end
                if (v < r.min_val) begin
                    n.min_val = v;
                end
            end
            case (r.maxmin)
                mfc_pkg::MM_MAX: shown = n.max_val;
                mfc_pkg::MM_MIN: shown = n.min_val;
                default: shown = v;
            endcase
            if (!r.hold && r.inrush == mfc_pkg::IR_OFF) begin
                n.disp_val = shown;
                n.over = v_over;
            end
        end

        // Single inrush capture, then hold the reading
        if (I_INRUSH_DET && r.inrush == mfc_pkg::IR_ARMED) begin
            n.disp_val = I_CONV_VALUE;
            n.over = mag(I_CONV_VALUE) > `MFC_FULL_SCALE;
            n.inrush = mfc_pkg::IR_HELD;
        end

        // Automatic range steps from the converter
        if (r.auto_rng && r.inrush == mfc_pkg::IR_OFF) begin
            if (I_AUTO_UP && r.range < hi) begin
                n.range = r.range + 3'h1;
                if (r.zero) begin
                    n.offset = r.offset / `MFC_ZERO_DIV;
                end
            end else if (I_AUTO_DOWN && r.range > lo_auto) begin
                n.range = r.range - 3'h1;
            end
        end

        // Hold toggle; entering hold in auto drops to manual unless zero is on
        if (b_press[`MFC_BTN_HOLD]) begin
            n.hold = ~r.hold;
            if (!r.hold && r.auto_rng && !r.zero) begin
                n.auto_rng = 1'b0;
            end
        end

        // Relative toggle, not offered in clamp DC current
        if (b_press[`MFC_BTN_REL] && I_MEAS_MODE != mfc_pkg::MODE_DCA_AUTO &&
            I_MEAS_MODE != mfc_pkg::MODE_DCA_MAN && r.inrush == mfc_pkg::IR_OFF) begin
            if (r.relative_mode) begin
                n.relative_mode = 1'b0;
                n.offset = '0;
            end else begin
                n.relative_mode = 1'b1;
                n.offset = r.disp_val;
                n.ref_over = r.over;
            end
        end

        // Max/min cycling and long-press exit
        if (b_short[`MFC_BTN_MAXMIN] && r.inrush == mfc_pkg::IR_OFF) begin
            case (r.maxmin)
                mfc_pkg::MM_OFF: begin
                    n.maxmin = mfc_pkg::MM_MAX;
                    n.max_val = r.disp_val;
                    n.min_val = r.disp_val;
                    n.disp_val = r.disp_val;
                end
                mfc_pkg::MM_MAX: n.maxmin = mfc_pkg::MM_MIN;
                mfc_pkg::MM_MIN: n.maxmin = mfc_pkg::MM_LIVE;
                default: n.maxmin = mfc_pkg::MM_MAX;
            endcase
        end
        if (b_long[`MFC_BTN_MAXMIN]) begin
            n.maxmin = mfc_pkg::MM_OFF;
        end

        // Zero: clamp DC current only, refused on the higher auto range
        if (b_short[`MFC_BTN_ZERO] && (I_MEAS_MODE == mfc_pkg::MODE_DCA_AUTO ||
            I_MEAS_MODE == mfc_pkg::MODE_DCA_MAN)) begin
            if (r.zero) begin
                n.offset = r.last_conv;
            end else if (!(r.auto_rng && r.range == hi)) begin
                n.zero = 1'b1;
                n.offset = r.last_conv;
            end
        end
        if (b_long[`MFC_BTN_ZERO] && r.zero) begin
            n.zero = 1'b0;
            n.offset = '0;
        end

        // Key: inrush entry, re-arm and exit
        if (b_short[`MFC_BTN_KEY] && ir_enabled && !fc5 &&
            (I_MEAS_MODE == mfc_pkg::MODE_ACA_AUTO || I_MEAS_MODE == mfc_pkg::MODE_ACA_MAN)) begin
            n.inrush = mfc_pkg::IR_ARMED;
            if (r.inrush == mfc_pkg::IR_OFF) begin
                n.ir_was_auto = r.auto_rng;
                n.hold = 1'b0;
                n.maxmin = mfc_pkg::MM_OFF;
                if (r.auto_rng) begin
                    n.range = hi;
                    n.auto_rng = 1'b0;
                end
            end
        end
        if (b_long[`MFC_BTN_KEY] && r.inrush != mfc_pkg::IR_OFF) begin
            n.inrush = mfc_pkg::IR_OFF;
            n.auto_rng = r.ir_was_auto;
            if (r.ir_was_auto) begin
                n.range = range_init(I_MEAS_MODE);
            end
        end

        // Range button: clear specials, then toggle or step
        if (b_press[`MFC_BTN_RANGE]) begin
            n.relative_mode = 1'b0;
            n.hold = 1'b0;
            n.maxmin = mfc_pkg::MM_OFF;
            n.zero = 1'b0;
            n.inrush = mfc_pkg::IR_OFF;
            n.offset = '0;
            n.range = r.range;
            n.auto_rng = r.auto_rng;
            if (!is_fixed(I_MEAS_MODE)) begin
                if (r.auto_rng) begin
                    n.auto_rng = 1'b0;
                end else if (r.range >= hi) begin
                    n.range = lo_man;
                end else begin
                    n.range = r.range + 3'h1;
                end
            end
        end

        // Long range press returns to automatic ranging
        if (b_long[`MFC_BTN_RANGE] && !is_fixed(I_MEAS_MODE)) begin
            n.auto_rng = 1'b1;
            if (r.range < lo_auto) begin
                n.range = lo_auto;
            end
        end

        // Mode change wins over everything
        if (I_MEAS_MODE != r.mode) begin
            n.relative_mode = 1'b0;
            n.hold = 1'b0;
            n.maxmin = mfc_pkg::MM_OFF;
            n.zero = 1'b0;
            n.inrush = mfc_pkg::IR_OFF;
            n.offset = '0;
            n.range = range_init(I_MEAS_MODE);
            n.auto_rng = ~is_fixed(I_MEAS_MODE);
        end
    end

    // State register
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            r <= '0;
            r.range <= `MFC_VOLT_INIT;
            r.auto_rng <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from state
    assign O_RANGE = r.range;
    assign O_AUTO = r.auto_rng;
    assign O_DISP_VALUE = r.disp_val;
    assign O_DISP_DASHES = (r.inrush == mfc_pkg::IR_ARMED);
    assign O_OVERLOAD_INDICATION = r.over;
    assign O_RELATIVE_MODE = r.relative_mode;
    assign O_HOLD = r.hold;
    assign O_MAXMIN_SEL = r.maxmin;
    assign O_INRUSH = (r.inrush != mfc_pkg::IR_OFF);
    assign O_ZERO = r.zero;

endmodule : mfc_push_ctrl
`default_nettype wire

// ---- design/mfc_regs.svh ----
// Constants for the meter push-function controller
`ifndef MFC_REGS_SVH
`define MFC_REGS_SVH

// Timing: long press threshold in milliseconds, core clock in kHz
`define MFC_LONG_PRESS_MS 1000
`define MFC_CLK_KHZ 25000
`define MFC_PRESS_CNT_W 25

// Display limits in counts and the zero offset divisor
`define MFC_FULL_SCALE 16'sh19C8
`define MFC_REL_LIMIT 16'sh270F
`define MFC_ZERO_DIV 16'sh000A

// Range indices, range one is index zero
`define MFC_RANGE_ONE 3'h0
`define MFC_VOLT_AUTO_LO 3'h1
`define MFC_VOLT_HI 3'h4
`define MFC_VOLT_INIT 3'h1
`define MFC_TWO_HI 3'h1
`define MFC_CAP_HI 3'h7
`define MFC_CCAP_LO 3'h3
`define MFC_CCAP_HI_LIM 3'h6
`define MFC_SIX_HI 3'h5

// Button indices
`define MFC_BTN_NUM 6
`define MFC_BTN_RANGE 0
`define MFC_BTN_HOLD 1
`define MFC_BTN_REL 2
`define MFC_BTN_MAXMIN 3
`define MFC_BTN_KEY 4
`define MFC_BTN_ZERO 5

`endif

// ---- design/mfc_pkg.sv ----
// Types for the meter push-function controller
package mfc_pkg;

    // Measurement mode class from the mode decoder
    typedef enum logic [3:0] {
        MODE_VOLT,
        MODE_TWO_RANGE,
        MODE_ACA_AUTO,
        MODE_ACA_MAN,
        MODE_DCA_AUTO,
        MODE_DCA_MAN,
        MODE_CAP,
        MODE_CLAMP_CAP,
        MODE_RES,
        MODE_FREQ,
        MODE_FIXED
    } mfc_mode_t;

    // Max/min display selection
    typedef enum logic [1:0] {MM_OFF, MM_MAX, MM_MIN, MM_LIVE} mfc_mm_t;

    // Inrush capture state
    typedef enum logic [1:0] {IR_OFF, IR_ARMED, IR_HELD} mfc_ir_t;

    // Button conditioner state
    typedef struct packed {
        logic s1;
        logic s2;
        logic lvl;
        logic [24:0] cnt;
        logic long_done;
        logic press_p;
        logic short_p;
        logic long_p;
    } mfc_btn_t;

    // Controller state
    typedef struct packed {
        logic [2:0] strap_s1;
        logic [2:0] strap_s2;
        mfc_mode_t mode;
        logic [2:0] range;
        logic auto_rng;
        logic relative_mode;
        logic hold;
        logic zero;
        mfc_mm_t maxmin;
        mfc_ir_t inrush;
        logic ir_was_auto;
        logic ref_over;
        logic signed [15:0] offset;
        logic signed [15:0] last_conv;
        logic signed [15:0] max_val;
        logic signed [15:0] min_val;
        logic signed [15:0] disp_val;
        logic over;
    } mfc_state_t;

endpackage : mfc_pkg

// ---- design/mfc_button.sv ----
// Push button conditioner: synchroniser, press, short and long press pulses
`timescale 1ns/1ps
`default_nettype none
`include "mfc_regs.svh"

module mfc_button #(
    parameter int unsigned LONG_CYCLES = `MFC_LONG_PRESS_MS * `MFC_CLK_KHZ
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_btn_n,
    output logic o_press,
    output logic o_short,
    output logic o_long
);

    mfc_pkg::mfc_btn_t r;
    mfc_pkg::mfc_btn_t n;
    logic [24:0] lim;

    assign lim = LONG_CYCLES[24:0];

    // Next state: sync, edge detect, hold time count
    always_comb begin
        n = r;
        n.s1 = ~i_btn_n;
        n.s2 = r.s1;
        n.lvl = r.s2;
        n.press_p = r.s2 & ~r.lvl;
        n.short_p = 1'b0;
        n.long_p = 1'b0;
        if (r.s2 && !r.lvl) begin
            n.cnt = '0;
            n.long_done = 1'b0;
        end else if (r.s2) begin
            if (!r.long_done) begin
                n.cnt = r.cnt + 25'h0000001;
            end
            if (!r.long_done && r.cnt >= lim) begin
                n.long_done = 1'b1;
                n.long_p = 1'b1; // Fires while still held
            end
        end else if (r.lvl && !r.long_done) begin
            n.short_p = 1'b1; // Release before the threshold
        end
    end

    // State register
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign o_press = r.press_p;
    assign o_short = r.short_p;
    assign o_long = r.long_p;

endmodule : mfc_button
`default_nettype wire

// ---- bench/mfc_push_ctrl_asserts.sv ----
// Port checker for the meter push-function controller
`timescale 1ns/1ps
`default_nettype none
`include "mfc_regs.svh"
module mfc_push_ctrl_asserts #(
    parameter int unsigned LONG_PRESS_CYCLES = 20
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RESET,
    input wire logic I_RANGE_BTN_N,
    input wire logic I_INRUSH_ENABLE_PIN_N,
    input wire logic I_FUNCTION_CODE_BIT_FIVE,
    input wire mfc_pkg::mfc_mode_t I_MEAS_MODE,
    input wire logic I_CONV_VALID,
    input wire logic signed [15:0] I_CONV_VALUE,
    input wire logic I_AUTO_UP,
    input wire logic [2:0] O_RANGE,
    input wire logic O_AUTO,
    input wire logic signed [15:0] O_DISP_VALUE,
    input wire logic O_DISP_DASHES,
    input wire logic O_OVERLOAD_INDICATION,
    input wire logic O_RELATIVE_MODE,
    input wire logic O_HOLD,
    input wire mfc_pkg::mfc_mm_t O_MAXMIN_SEL,
    input wire logic O_INRUSH,
    input wire logic O_ZERO
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RESET);
    // No special mode active
    logic plain;
    assign plain = !O_HOLD && !O_RELATIVE_MODE && !O_ZERO && !O_INRUSH
        && O_MAXMIN_SEL == mfc_pkg::MM_OFF;
    sequence s_range_press; $fell(I_RANGE_BTN_N); endsequence
    sequence s_plain; plain; endsequence
    property p_conv_disp;
        I_CONV_VALID && plain && $stable(I_MEAS_MODE)
        |=> !plain || O_DISP_VALUE == $past(I_CONV_VALUE);
    endproperty
    a_conv_disp: assert property (p_conv_disp) else $error("display not loaded");
    property p_rel_ovl;
        O_RELATIVE_MODE && !O_HOLD && I_CONV_VALID
        && (I_CONV_VALUE > `MFC_FULL_SCALE || I_CONV_VALUE < -`MFC_FULL_SCALE)
        |=> O_OVERLOAD_INDICATION || !O_RELATIVE_MODE || O_HOLD;
    endproperty
    a_rel_ovl: assert property (p_rel_ovl) else $error("relative overload missing");
    property p_hold_frz; O_HOLD ##1 O_HOLD |-> $stable(O_DISP_VALUE); endproperty
    a_hold_frz: assert property (p_hold_frz) else $error("display moved in hold");
    property p_range_clr; s_range_press |-> ##[1:6] s_plain; endproperty
    a_range_clr: assert property (p_range_clr) else $error("specials kept");
    property p_fixed;
        I_MEAS_MODE == mfc_pkg::MODE_FIXED && $past(I_MEAS_MODE) == mfc_pkg::MODE_FIXED
        && $past(I_MEAS_MODE, 2) == mfc_pkg::MODE_FIXED |-> !O_AUTO && O_RANGE == `MFC_RANGE_ONE;
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed range moved");
    property p_volt_auto;
        O_AUTO && I_MEAS_MODE == mfc_pkg::MODE_VOLT && $past(I_MEAS_MODE) == mfc_pkg::MODE_VOLT
        |-> O_RANGE >= `MFC_VOLT_AUTO_LO && O_RANGE <= `MFC_VOLT_HI;
    endproperty
    a_volt_auto: assert property (p_volt_auto) else $error("voltage auto range");
    property p_dash; O_DISP_DASHES |-> O_INRUSH; endproperty
    a_dash: assert property (p_dash) else $error("dashes outside inrush");
    property p_ir_gate;
        $rose(O_INRUSH) |-> $past(!I_INRUSH_ENABLE_PIN_N && !I_FUNCTION_CODE_BIT_FIVE)
        && $past(I_MEAS_MODE) inside {mfc_pkg::MODE_ACA_AUTO, mfc_pkg::MODE_ACA_MAN};
    endproperty
    a_ir_gate: assert property (p_ir_gate) else $error("inrush not allowed");
    property p_ir_range;
        $rose(O_INRUSH) && $past(O_AUTO) |-> O_RANGE == `MFC_TWO_HI && !O_AUTO;
    endproperty
    a_ir_range: assert property (p_ir_range) else $error("inrush range");
    property p_zero_gate;
        $rose(O_ZERO) |-> $past(I_MEAS_MODE) inside {mfc_pkg::MODE_DCA_AUTO,
        mfc_pkg::MODE_DCA_MAN} && !($past(O_AUTO) && $past(O_RANGE) == `MFC_TWO_HI);
    endproperty
    a_zero_gate: assert property (p_zero_gate) else $error("zero not allowed");
    property p_zero_up;
        O_ZERO && O_AUTO && !O_HOLD && I_AUTO_UP && O_RANGE == `MFC_RANGE_ONE
        && $stable(I_MEAS_MODE) && I_RANGE_BTN_N |=> O_ZERO && O_AUTO && O_RANGE == `MFC_TWO_HI;
    endproperty
    a_zero_up: assert property (p_zero_up) else $error("zero autorange");
    property p_mm_order;
        $changed(O_MAXMIN_SEL) && $past(O_MAXMIN_SEL) == mfc_pkg::MM_MAX
        |-> O_MAXMIN_SEL inside {mfc_pkg::MM_MIN, mfc_pkg::MM_OFF};
    endproperty
    a_mm_order: assert property (p_mm_order) else $error("max/min order");
endmodule : mfc_push_ctrl_asserts
bind mfc_push_ctrl mfc_push_ctrl_asserts #(.LONG_PRESS_CYCLES(LONG_PRESS_CYCLES)) u_chk (
    .I_CORE_CLK(I_CORE_CLK), .I_RESET(I_RESET), .I_RANGE_BTN_N(I_RANGE_BTN_N),
    .I_INRUSH_ENABLE_PIN_N(I_INRUSH_ENABLE_PIN_N),
    .I_FUNCTION_CODE_BIT_FIVE(I_FUNCTION_CODE_BIT_FIVE), .I_MEAS_MODE(I_MEAS_MODE),
    .I_CONV_VALID(I_CONV_VALID), .I_CONV_VALUE(I_CONV_VALUE), .I_AUTO_UP(I_AUTO_UP),
    .O_RANGE(O_RANGE), .O_AUTO(O_AUTO), .O_DISP_VALUE(O_DISP_VALUE),
    .O_DISP_DASHES(O_DISP_DASHES), .O_OVERLOAD_INDICATION(O_OVERLOAD_INDICATION),
    .O_RELATIVE_MODE(O_RELATIVE_MODE), .O_HOLD(O_HOLD), .O_MAXMIN_SEL(O_MAXMIN_SEL),
    .O_INRUSH(O_INRUSH), .O_ZERO(O_ZERO));
`default_nettype wire

// ---- bench/mfc_panel_model.sv ----
// Model of the push buttons and board strap pins
`timescale 1ns/1ps
`default_nettype none
module mfc_panel_model (
    input wire logic i_clk,
    output var logic [5:0] o_btn_n,
    output var logic o_cap_lim_n,
    output var logic o_ir_en_n,
    output var logic o_fc5
);
    // Buttons released, straps floating at power-up
    initial begin
        o_btn_n = 6'h3F;
        o_cap_lim_n = 1'b1;
        o_ir_en_n = 1'b1;
        o_fc5 = 1'b1;
    end
    // Hold one button low for n cycles, then let it settle
    task automatic press(input int idx, input int n);
        @(negedge i_clk) o_btn_n[idx] = 1'b0;
        repeat (n) @(negedge i_clk);
        o_btn_n[idx] = 1'b1;
        repeat (8) @(negedge i_clk);
    endtask : press
    // Inrush needs its enable strap and bit five tied low
    task automatic straps(input logic cap_n, input logic ir_n, input logic fc5);
        @(negedge i_clk);
        o_cap_lim_n = cap_n;
        o_ir_en_n = ir_n;
        o_fc5 = fc5;
        repeat (4) @(negedge i_clk);
    endtask : straps
endmodule : mfc_panel_model
`default_nettype wire

// ---- bench/tb.sv ----
// Testbench for the meter push-function controller
`timescale 1ns/1ps
`default_nettype none
`include "mfc_regs.svh"
module tb;
    localparam int unsigned LONG = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    mfc_pkg::mfc_mode_t mode = mfc_pkg::MODE_VOLT;
    logic cv = 1'b0;
    logic signed [15:0] cval = 16'h0000;
    logic up = 1'b0;
    logic det = 1'b0;
    logic dn = 1'b0;
    logic [5:0] btn_n;
    logic cap_n, ir_n, fc5, aut, dash, ovl, relative_mode, hold, irm, zero;
    logic [2:0] rng, r;
    logic signed [15:0] disp;
    mfc_pkg::mfc_mm_t mm;
    int err_total = 0;
    int n_tests = 0;
    // Mode table for the range walk
    mfc_pkg::mfc_mode_t ml[8] = '{mfc_pkg::MODE_VOLT, mfc_pkg::MODE_TWO_RANGE,
        mfc_pkg::MODE_CAP, mfc_pkg::MODE_CLAMP_CAP, mfc_pkg::MODE_CLAMP_CAP,
        mfc_pkg::MODE_RES, mfc_pkg::MODE_FREQ, mfc_pkg::MODE_FIXED};
    logic [2:0] lo[8] = '{3'h0, 3'h0, 3'h0, 3'h3, 3'h3, 3'h0, 3'h0, 3'h0};
    logic [2:0] hi[8] = '{3'h4, 3'h1, 3'h7, 3'h7, 3'h6, 3'h5, 3'h5, 3'h0};
    logic [2:0] ini[8] = '{3'h1, 3'h0, 3'h0, 3'h3, 3'h3, 3'h0, 3'h0, 3'h0};
    mfc_panel_model pm (.i_clk(clk), .o_btn_n(btn_n), .o_cap_lim_n(cap_n),
        .o_ir_en_n(ir_n), .o_fc5(fc5));
    mfc_push_ctrl #(.LONG_PRESS_CYCLES(LONG)) dut (.I_CORE_CLK(clk), .I_RESET(rst),
        .I_RANGE_BTN_N(btn_n[`MFC_BTN_RANGE]), .I_HOLD_BTN_N(btn_n[`MFC_BTN_HOLD]),
        .I_REL_BTN_N(btn_n[`MFC_BTN_REL]), .I_MAXMIN_BTN_N(btn_n[`MFC_BTN_MAXMIN]),
        .I_KEY_BTN_N(btn_n[`MFC_BTN_KEY]), .I_ZERO_BTN_N(btn_n[`MFC_BTN_ZERO]),
        .I_CLAMP_CAP_LIMIT_PIN_N(cap_n), .I_INRUSH_ENABLE_PIN_N(ir_n),
        .I_FUNCTION_CODE_BIT_FIVE(fc5), .I_MEAS_MODE(mode), .I_CONV_VALID(cv),
        .I_CONV_VALUE(cval), .I_AUTO_UP(up), .I_AUTO_DOWN(dn), .I_INRUSH_DET(det),
        .O_RANGE(rng), .O_AUTO(aut), .O_DISP_VALUE(disp), .O_DISP_DASHES(dash),
        .O_OVERLOAD_INDICATION(ovl), .O_RELATIVE_MODE(relative_mode), .O_HOLD(hold),
        .O_MAXMIN_SEL(mm), .O_INRUSH(irm), .O_ZERO(zero));
    // 25 MHz core clock
    initial begin
        forever #20 clk = ~clk;
    end
    // Verdict and end of run
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    // Compare one result
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One conversion pulse
    task automatic conv(input logic [15:0] v);
        @(negedge clk);
        cv = 1'b1;
        cval = v;
        @(negedge clk);
        cv = 1'b0;
    endtask : conv
    // Mode switch and settle
    task automatic setmode(input mfc_pkg::mfc_mode_t m);
        @(negedge clk);
        mode = m;
        repeat (4) @(negedge clk);
    endtask : setmode
    // Short or long button press
    task automatic push(input int idx, input bit lng);
        pm.press(idx, lng ? LONG + 8 : 3);
    endtask : push
    // Hang guard
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        conclude();
    end
    // Main sequence
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk(rng, `MFC_VOLT_INIT);
        chk(aut, 1'b1);
        @(negedge clk);
        dn = 1'b1;
        @(negedge clk);
        dn = 1'b0;
        chk(rng, `MFC_VOLT_INIT);
        for (int i = 0; i < 8; i++) begin
            pm.straps(i != 4, 1'b1, 1'b1);
            setmode(mfc_pkg::MODE_FIXED);
            setmode(ml[i]);
            r = ini[i];
            chk(rng, r);
            chk(aut, ml[i] != mfc_pkg::MODE_FIXED);
            push(`MFC_BTN_RANGE, 1'b0);
            chk(aut, 1'b0);
            chk(rng, r);
            for (int k = 0; k <= hi[i] - lo[i]; k++) begin
                push(`MFC_BTN_RANGE, 1'b0);
                if (ml[i] != mfc_pkg::MODE_FIXED) r = (r == hi[i]) ? lo[i] : r + 3'h1;
                chk(rng, r);
            end
        end
        // Relative with hold, cleared by range
        setmode(mfc_pkg::MODE_VOLT);
        conv(16'hF448);
        push(`MFC_BTN_REL, 1'b0);
        chk(relative_mode, 1'b1);
        conv(16'h1388);
        chk(disp, 16'h1F40);
        chk(ovl, 1'b0);
        conv(16'h1A2C);
        chk(ovl, 1'b1);
        conv(16'h0064);
        chk(disp, 16'h0C1C);
        push(`MFC_BTN_HOLD, 1'b0);
        conv(16'h0384);
        chk(disp, 16'h0C1C);
        chk(relative_mode, 1'b1);
        push(`MFC_BTN_RANGE, 1'b0);
        chk(hold, 1'b0);
        chk(relative_mode, 1'b0);
        // Max/min cycle with frozen tracking
        conv(16'h000A);
        push(`MFC_BTN_MAXMIN, 1'b0);
        chk(mm, mfc_pkg::MM_MAX);
        conv(16'h0032);
        conv(16'hFFEC);
        chk(disp, 16'h0032);
        push(`MFC_BTN_MAXMIN, 1'b0);
        conv(16'hFFF6);
        chk(disp, 16'hFFEC);
        push(`MFC_BTN_HOLD, 1'b0);
        conv(16'hFF9C);
        push(`MFC_BTN_HOLD, 1'b0);
        chk(hold, 1'b0);
        conv(16'hFFF6);
        chk(disp, 16'hFFEC);
        push(`MFC_BTN_MAXMIN, 1'b0);
        chk(mm, mfc_pkg::MM_LIVE);
        push(`MFC_BTN_MAXMIN, 1'b1);
        chk(mm, mfc_pkg::MM_OFF);
        // Inrush refused, then armed, captured, re-armed, left
        setmode(mfc_pkg::MODE_ACA_AUTO);
        push(`MFC_BTN_KEY, 1'b0);
        chk(irm, 1'b0);
        pm.straps(1'b1, 1'b0, 1'b0);
        push(`MFC_BTN_KEY, 1'b0);
        chk(dash, 1'b1);
        chk(rng, `MFC_TWO_HI);
        chk(aut, 1'b0);
        @(negedge clk);
        det = 1'b1;
        cval = 16'h01F4;
        @(negedge clk);
        det = 1'b0;
        chk(dash, 1'b0);
        chk(disp, 16'h01F4);
        push(`MFC_BTN_KEY, 1'b0);
        chk(dash, 1'b1);
        push(`MFC_BTN_KEY, 1'b1);
        chk(irm, 1'b0);
        // Zero with refresh, autorange up and refusal on high range
        setmode(mfc_pkg::MODE_DCA_AUTO);
        conv(16'h001E);
        push(`MFC_BTN_ZERO, 1'b0);
        conv(16'h0032);
        chk(disp, 16'h0014);
        conv(16'h0028);
        push(`MFC_BTN_ZERO, 1'b0);
        conv(16'h0032);
        chk(disp, 16'h000A);
        @(negedge clk);
        up = 1'b1;
        @(negedge clk);
        up = 1'b0;
        chk(rng, `MFC_TWO_HI);
        chk(aut, 1'b1);
        conv(16'h0032);
        chk(disp, 16'h002E);
        push(`MFC_BTN_ZERO, 1'b1);
        chk(zero, 1'b0);
        push(`MFC_BTN_ZERO, 1'b0);
        chk(zero, 1'b0);
        conclude();
    end
endmodule : tb
`default_nettype wire
